/* File: design/ucw_device.sv */
// peripheral end: command decoder, register lock, suspend and wake-up sequencer
// What this block does
// - wake on K-state, wake input, or chip select
// - restart oscillator, gate clocks until stable
// - drop suspend output, set resume flag
// - resume normal operation within 15 ms
// - remote wake drives K-state 10 ms
// - host restores system after suspend drops
// - writes blocked after wake until unlocked
// - unlock command plus key restores writes
// - flag suspend entry, interrupt if enabled
// - live bus suspend state status bit
// - suspend request high then low enters suspend
// - pull-up enable, pull-up select, powered-off select
// - select high: low byte is command
// - select low: data phase, low first
// - sixteen-bit mode ignores undefined bytes
// - fifo writes take the low byte only, upper byte dropped
// - check status reads without clearing
// - decode configuration commands
// - fifo write commands
// - stall, unstall, acknowledge setup commands
// - validate and clear for any endpoint index
// - error code, scratch, frame, interrupt reads
`timescale 1ns/1ps
module ucw_device #(
    parameter int RESUME_CYCLES = ucw_pkg::RESUME_CYC,
    parameter int KSTATE_CYCLES = ucw_pkg::KSTATE_CYC,
    parameter int STABLE_CYCLES = ucw_pkg::STABLE_CYC_DEF
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    ucw_if.dev        bus,
    input  wire logic busKState,
    input  wire logic busSuspendState,
    input  wire logic vbusPresent,
    input  wire logic wide16,
    input  wire logic [10:0] frameNumber,
    output logic      clockStable,
    output logic      clocksRouted,
    output logic      driveKState,
    output logic      softPullupEnable,
    output logic      externalPullupSelect,
    output logic      poweredOffSelect,
    output logic      fifoStrobe,
    output logic [7:0] fifoByte,
    output logic [3:0] epCmdIndex,
    output logic [7:0] epCmdCode,
    output logic      epCmdPulse
);
    import ucw_pkg::*;

    typedef enum logic [2:0] {
        ST_AWAKE   = 3'b000,
        ST_SUSP    = 3'b001,
        ST_OSC     = 3'b010,
        ST_RESUME  = 3'b011
    } ucw_pwr_t;

    typedef struct packed {
        logic [2:0]  wsync;
        logic [2:0]  csync;
        logic [2:0]  rsync;
        ucw_pwr_t    pwr;
        logic [23:0] tmr;
        logic [23:0] ktmr;
        logic        remote;
        logic        locked;
        logic [7:0]  cmd;
        logic [1:0]  idx;
        logic [15:0] key;
        logic [7:0]  mode;
        logic [15:0] hwc;
        logic [15:0] scratch;
        logic [31:0] ien;
        logic [31:0] intr;
        logic [15:0] dout;
        logic        oe;
        logic        fstb;
        logic [7:0]  fbyte;
        logic        epPulse;
        logic [7:0]  epCfg;
        logic [7:0]  epStatus;
        logic [7:0]  addr;
    } ucw_state_t;

    ucw_state_t s_reg;
    ucw_state_t s_next;

    function automatic logic isData(input logic [7:0] c, input logic [7:0] base);
        return c[7:4] == base[7:4];
    endfunction

    // 8-bit bus hands out bytes, 16-bit bus words, low part first
    function automatic logic [15:0] pickPart(input logic [31:0] w, input logic [1:0] i,
                                             input logic wide);
        if (wide) return i[0] ? w[31:16] : w[15:0];
        return {8'h00, w[8*i +: 8]};
    endfunction

    logic wrEdge;
    logic setSusp;
    logic setRes;
    logic wakeHi;
    logic csLo;
    logic [7:0] lowByte;
    logic [15:0] rdWord;

    always_comb begin
        s_next = s_reg;
        s_next.wsync = {s_reg.wsync[1:0], bus.remoteWakeInput};
        s_next.csync = {s_reg.csync[1:0], bus.csN};
        s_next.rsync = {s_reg.rsync[1:0], ~bus.wrN & ~bus.csN};
        s_next.fstb = 1'b0;
        s_next.epPulse = 1'b0;
        wakeHi = s_reg.wsync[1] & s_reg.wsync[2];
        csLo = ~s_reg.csync[1] & ~s_reg.csync[2];
        wrEdge = 1'b0;
        setSusp = 1'b0;
        setRes = 1'b0;
        lowByte = bus.hostData[7:0];
        rdWord = 16'h0000;
        // write strobe seen after sync; read strobe sampled directly for the data drive
        if (s_reg.rsync[1] & ~s_reg.rsync[2]) begin
            wrEdge = 1'b1;
        end
        s_next.oe = ~bus.rdN & ~bus.csN;
        s_next.intr[INT_BUSST] = busSuspendState;
        unique case (s_reg.pwr)
            ST_AWAKE: begin
                // suspend entry is decided after the mode write further down
            end
            ST_SUSP: begin
                if (busKState | wakeHi | (csLo & s_reg.hwc[HWC_CSWAKE] & vbusPresent)) begin
                    s_next.pwr = ST_OSC;
                    s_next.remote = ~busKState;
                    s_next.tmr = 24'h000000;
                end
            end
            ST_OSC: begin
                s_next.tmr = s_reg.tmr + 24'h000001;
                if (s_reg.tmr >= 24'(STABLE_CYCLES - 1)) begin
                    s_next.pwr = ST_RESUME;
                    setRes = 1'b1;
                    s_next.ktmr = s_reg.remote ? 24'(KSTATE_CYCLES) : 24'h000000;
                end
            end
            ST_RESUME: begin
                s_next.tmr = s_reg.tmr + 24'h000001;
                if (s_reg.tmr >= 24'(RESUME_CYCLES - 2)) begin
                    s_next.pwr = ST_AWAKE;
                end
            end
            default: s_next.pwr = ST_AWAKE;
        endcase
        if (s_reg.ktmr != 24'h000000) begin
            s_next.ktmr = s_reg.ktmr - 24'h000001;
        end
        if (s_reg.pwr == ST_AWAKE || s_reg.pwr == ST_RESUME) begin
            if (wrEdge & bus.cmdDataSelect) begin
                s_next.cmd = lowByte;
                s_next.idx = 2'b00;
                if (isData(lowByte, CMD_STALL) || isData(lowByte, CMD_UNSTALL) ||
                    isData(lowByte, CMD_VALIDATE) || isData(lowByte, CMD_CLEAR) ||
                    lowByte == CMD_ACK_SETUP) begin
                    s_next.epPulse = 1'b1;
                end
                if (lowByte == CMD_RESET && !s_reg.locked) begin
                    s_next.mode = 8'h00;
                    s_next.ien = 32'h00000000;
                    s_next.scratch = 16'h0000;
                end
            end else if (wrEdge) begin
                s_next.idx = s_reg.idx + 2'b01;
                if (s_reg.cmd == CMD_UNLOCK) begin
                    if (wide16) begin
                        if (bus.hostData == UNLOCK_KEY) s_next.locked = 1'b0;
                    end else if (s_reg.idx == 2'b00) begin
                        s_next.key[7:0] = lowByte;
                    end else if ({lowByte, s_reg.key[7:0]} == UNLOCK_KEY) begin
                        s_next.locked = 1'b0;
                    end
                end else if (!s_reg.locked) begin
                    unique case (s_reg.cmd)
                        CMD_MODE_WR: s_next.mode = lowByte;
                        CMD_ADDR_WR: s_next.addr = lowByte;
                        CMD_HWC_WR: if (wide16) s_next.hwc = bus.hostData;
                                    else if (s_reg.idx[0]) s_next.hwc[15:8] = lowByte;
                                    else s_next.hwc[7:0] = lowByte;
                        CMD_SCR_WR: if (wide16) s_next.scratch = bus.hostData;
                                    else if (s_reg.idx[0]) s_next.scratch[15:8] = lowByte;
                                    else s_next.scratch[7:0] = lowByte;
                        CMD_IEN_WR: if (wide16) s_next.ien[16*s_reg.idx[0] +: 16] = bus.hostData;
                                    else s_next.ien[8*s_reg.idx +: 8] = lowByte;
                        default: begin
                            if (isData(s_reg.cmd, CMD_EPCFG_WR)) s_next.epCfg = lowByte;
                            if (isData(s_reg.cmd, CMD_FIFO_WR) && s_reg.cmd != CMD_FIFO_WR) begin
                                s_next.fstb = 1'b1;
                                s_next.fbyte = lowByte;
                            end
                        end
                    endcase
                end
            end
        end
        // the fall of the request bit is seen against this cycle's mode write
        if (s_reg.pwr == ST_AWAKE && s_reg.mode[MODE_SUSPREQ] && !s_next.mode[MODE_SUSPREQ]) begin
            s_next.pwr = ST_SUSP;
            setSusp = 1'b1;
            s_next.locked = 1'b1;
        end
        // read data presented when the read strobe is low, low byte or word first
        if (~bus.rdN & ~bus.csN & ~bus.cmdDataSelect) begin
            unique case (s_reg.cmd)
                CMD_MODE_RD: rdWord = {8'h00, s_reg.mode};
                CMD_ADDR_RD: rdWord = {8'h00, s_reg.addr};
                CMD_HWC_RD: rdWord = pickPart({16'h0000, s_reg.hwc}, s_reg.idx, wide16);
                CMD_SCR_RD: rdWord = pickPart({16'h0000, s_reg.scratch}, s_reg.idx, wide16);
                CMD_FRAME_RD: rdWord = pickPart({21'h00000, frameNumber}, s_reg.idx, wide16);
                CMD_INT_RD: rdWord = pickPart(s_reg.intr, s_reg.idx, wide16);
                CMD_IEN_RD: rdWord = pickPart(s_reg.ien, s_reg.idx, wide16);
                default: begin
                    if (isData(s_reg.cmd, CMD_EPCFG_RD)) rdWord = {8'h00, s_reg.epCfg};
                    if (isData(s_reg.cmd, CMD_CHECK) || isData(s_reg.cmd, CMD_STATUS_RD)) begin
                        rdWord = {8'h00, s_reg.epStatus};
                    end
                    if (isData(s_reg.cmd, CMD_ERR_RD)) rdWord = 16'h0000;
                end
            endcase
        end
        s_next.dout = rdWord;
        if (s_reg.oe & ~s_next.oe & ~bus.cmdDataSelect) begin
            s_next.idx = s_reg.idx + 2'b01;
            if (isData(s_reg.cmd, CMD_STATUS_RD)) s_next.epStatus = 8'h00;
            if (s_reg.cmd == CMD_INT_RD && s_reg.idx == 2'b01) begin
                s_next.intr[INT_SUSP] = 1'b0;
                s_next.intr[INT_RESUME] = 1'b0;
            end
        end
        // an event in the clearing cycle is not lost: set wins
        if (setSusp) s_next.intr[INT_SUSP] = 1'b1;
        if (setRes) s_next.intr[INT_RESUME] = 1'b1;
        if (!rst_n) begin
            s_next = '0;
            s_next.hwc = HWC_RESET;
            s_next.wsync = 3'b000;
            s_next.csync = 3'b111;
        end
    end

    always_ff @(posedge ref_clk) begin
        s_reg <= s_next;
    end

    assign bus.devData = s_reg.dout;
    assign bus.devDataOe = s_reg.oe;
    assign bus.suspendOut = (s_reg.pwr == ST_SUSP) || (s_reg.pwr == ST_OSC);
    assign bus.intOut = s_reg.mode[3] &
                        ((s_reg.intr[INT_RESUME] & s_reg.ien[INT_RESUME]) |
                         (s_reg.intr[INT_SUSP] & s_reg.ien[INT_SUSP]));
    assign clockStable = s_reg.pwr != ST_SUSP;
    assign clocksRouted = (s_reg.pwr == ST_AWAKE) || (s_reg.pwr == ST_RESUME);
    assign driveKState = s_reg.ktmr != 24'h000000;
    assign softPullupEnable = s_reg.mode[MODE_SOFTPU];
    assign externalPullupSelect = s_reg.hwc[HWC_EXTPU];
    assign poweredOffSelect = s_reg.hwc[HWC_POWERED_OFF_SELECT];
    assign fifoStrobe = s_reg.fstb;
    assign fifoByte = s_reg.fbyte;
    assign epCmdIndex = s_reg.cmd[3:0];
    assign epCmdCode = s_reg.cmd;
    assign epCmdPulse = s_reg.epPulse;
endmodule

/* File: design/ucw_host.sv */
// controller end: turns register orders into command and data cycles
`timescale 1ns/1ps
module ucw_host (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    ucw_if.host              bus,
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [15:0]      regRdata
);
    import ucw_pkg::*;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_SET  = 2'b01,
        HS_STB  = 2'b10,
        HS_HOLD = 2'b11
    } ucw_hst_t;

    typedef struct packed {
        ucw_hst_t    st;
        logic [3:0]  cnt;
        logic        isRead;
        logic        sel;
        logic [15:0] wdata;
        logic [15:0] rcap;
        logic [15:0] rdOut;
        logic        wake;
        logic [2:0]  susSync;
    } ucw_host_t;

    ucw_host_t h_reg;
    ucw_host_t h_next;

    always_comb begin
        h_next = h_reg;
        h_next.susSync = {h_reg.susSync[1:0], bus.suspendOut};
        h_next.rdOut = 16'h0000;
        unique case (h_reg.st)
            HS_IDLE: begin
                if (regWrite && (regAddr == HR_CMD || regAddr == HR_DATA)) begin
                    h_next.st = HS_SET;
                    h_next.sel = regAddr == HR_CMD;
                    h_next.isRead = 1'b0;
                    h_next.wdata = regWdata;
                end else if (regRead && regAddr == HR_RDATA) begin
                    h_next.st = HS_SET;
                    h_next.sel = 1'b0;
                    h_next.isRead = 1'b1;
                end
            end
            HS_SET: h_next.st = HS_STB;
            HS_STB: begin
                h_next.cnt = h_reg.cnt + 4'h1;
                if (h_reg.cnt == 4'h7) begin
                    h_next.st = HS_HOLD;
                    h_next.cnt = 4'h0;
                    if (h_reg.isRead) h_next.rcap = bus.devData;
                end
            end
            HS_HOLD: h_next.st = HS_IDLE;
        endcase
        if (regWrite && regAddr == HR_PINS) h_next.wake = regWdata[0];
        if (regRead) begin
            unique case (regAddr)
                HR_STAT: h_next.rdOut = {13'h0000, h_reg.susSync[2] & h_reg.susSync[1],
                                         bus.intOut, h_reg.st != HS_IDLE};
                HR_RDATA: h_next.rdOut = h_reg.rcap;
                HR_PINS: h_next.rdOut = {15'h0000, h_reg.wake};
                default: h_next.rdOut = 16'h0000;
            endcase
        end
        if (!rst_n) begin
            h_next = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        h_reg <= h_next;
    end

    assign bus.hostData = h_reg.wdata;
    assign bus.cmdDataSelect = h_reg.sel;
    assign bus.csN = h_reg.st == HS_IDLE;
    assign bus.wrN = ~(h_reg.st == HS_STB && !h_reg.isRead);
    assign bus.rdN = ~(h_reg.st == HS_STB && h_reg.isRead);
    assign bus.remoteWakeInput = h_reg.wake;
    assign regRdata = h_reg.rdOut;
endmodule

/* File: design/ucw_if.sv */
// parallel command bus between controller and peripheral
`timescale 1ns/1ps
interface ucw_if;
    logic [15:0] hostData;
    logic [15:0] devData;
    logic        devDataOe;
    logic        cmdDataSelect;
    logic        csN;
    logic        wrN;
    logic        rdN;
    logic        remoteWakeInput;
    logic        suspendOut;
    logic        intOut;
    modport dev  (input hostData, cmdDataSelect, csN, wrN, rdN, remoteWakeInput,
                  output devData, devDataOe, suspendOut, intOut);
    modport host (output hostData, cmdDataSelect, csN, wrN, rdN, remoteWakeInput,
                  input devData, devDataOe, suspendOut, intOut);
endinterface

/* File: design/ucw_pkg.sv */
// shared constants for the command port and wake-up control
package ucw_pkg;
    localparam int CLK_MHZ = 250;
    localparam int RESUME_MS = 15;
    localparam int RESUME_CYC = RESUME_MS * CLK_MHZ * 1000;
    localparam int KSTATE_MS = 10;
    localparam int KSTATE_CYC = KSTATE_MS * CLK_MHZ * 1000;
    localparam int STABLE_CYC_DEF = 1024;
    localparam logic [15:0] UNLOCK_KEY = 16'haa37;

    localparam logic [7:0] CMD_EPCFG_WR = 8'h20;
    localparam logic [7:0] CMD_EPCFG_RD = 8'h30;
    localparam logic [7:0] CMD_FIFO_WR = 8'h00;
    localparam logic [7:0] CMD_FIFO_RD = 8'h10;
    localparam logic [7:0] CMD_STALL = 8'h40;
    localparam logic [7:0] CMD_STATUS_RD = 8'h50;
    localparam logic [7:0] CMD_VALIDATE = 8'h60;
    localparam logic [7:0] CMD_CLEAR = 8'h70;
    localparam logic [7:0] CMD_UNSTALL = 8'h80;
    localparam logic [7:0] CMD_ERR_RD = 8'ha0;
    localparam logic [7:0] CMD_CHECK = 8'hd0;
    localparam logic [7:0] CMD_UNLOCK = 8'hb0;
    localparam logic [7:0] CMD_SCR_WR = 8'hb2;
    localparam logic [7:0] CMD_SCR_RD = 8'hb3;
    localparam logic [7:0] CMD_FRAME_RD = 8'hb4;
    localparam logic [7:0] CMD_ADDR_WR = 8'hb6;
    localparam logic [7:0] CMD_ADDR_RD = 8'hb7;
    localparam logic [7:0] CMD_MODE_WR = 8'hb8;
    localparam logic [7:0] CMD_MODE_RD = 8'hb9;
    localparam logic [7:0] CMD_HWC_WR = 8'hba;
    localparam logic [7:0] CMD_HWC_RD = 8'hbb;
    localparam logic [7:0] CMD_INT_RD = 8'hc0;
    localparam logic [7:0] CMD_IEN_WR = 8'hc2;
    localparam logic [7:0] CMD_IEN_RD = 8'hc3;
    localparam logic [7:0] CMD_DMA_WR = 8'hf0;
    localparam logic [7:0] CMD_DMA_RD = 8'hf1;
    localparam logic [7:0] CMD_DCNT_WR = 8'hf2;
    localparam logic [7:0] CMD_DCNT_RD = 8'hf3;
    localparam logic [7:0] CMD_ACK_SETUP = 8'hf4;
    localparam logic [7:0] CMD_RESET = 8'hf6;

    localparam int MODE_SUSPREQ = 5;
    localparam int MODE_SOFTPU = 0;
    localparam int HWC_EXTPU = 2;
    localparam int HWC_CSWAKE = 1;
    localparam int HWC_POWERED_OFF_SELECT = 0;
    localparam logic [15:0] HWC_RESET = 16'h0001;
    localparam int INT_RESUME = 1;
    localparam int INT_SUSP = 0;
    localparam int INT_BUSST = 8;

    // host control register map
    localparam logic [3:0] HR_CMD = 4'h0;
    localparam logic [3:0] HR_DATA = 4'h1;
    localparam logic [3:0] HR_STAT = 4'h2;
    localparam logic [3:0] HR_RDATA = 4'h3;
    localparam logic [3:0] HR_PINS = 4'h4;
endpackage

/* File: tb/ucw_checker_sva.sv */
// assertions on the command bus that joins the two ends
`timescale 1ns/1ps
module ucw_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [15:0] hostData,
    input wire logic [15:0] devData,
    input wire logic        devDataOe,
    input wire logic        cmdDataSelect,
    input wire logic        csN,
    input wire logic        wrN,
    input wire logic        rdN,
    input wire logic        remoteWakeInput,
    input wire logic        suspendOut,
    input wire logic        intOut
);
    // bench resume count plus slack for the input synchroniser
    localparam int WAKE_MAX = 60;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    oe_on_read_a: assert property ($rose(devDataOe) |-> !rdN && !csN)
        else $error("device drove the bus without a read");
    no_drive_wr_a: assert property (!wrN |-> !devDataOe)
        else $error("device drove the bus during a write");
    strobe_excl_a: assert property (!(!wrN && !rdN))
        else $error("write and read strobes low together");
    wr_width_a: assert property ($fell(wrN) |-> !wrN [*8] ##1 wrN)
        else $error("write strobe width wrong");
    rd_width_a: assert property ($fell(rdN) |-> !rdN [*8] ##1 rdN)
        else $error("read strobe width wrong");
    strobe_cs_a: assert property ((!wrN || !rdN) |-> !csN)
        else $error("strobe without chip select");
    wr_stable_a: assert property (!wrN && $past(!wrN) |-> $stable(hostData) && $stable(cmdDataSelect))
        else $error("write data moved under the strobe");
    rd_data_phase_a: assert property (!rdN |-> !cmdDataSelect)
        else $error("read made in command phase");
    wake_exit_a: assert property ($rose(remoteWakeInput) && suspendOut |-> ##[1:WAKE_MAX] !suspendOut)
        else $error("wake input did not end suspend in time");
endmodule

/* File: tb/usb_device_cmd_port_remote_wake_input_tb.sv */
// self-checking bench: host and device ends joined over the command bus
`timescale 1ns/1ps
module usb_device_cmd_port_remote_wake_input_tb;
    import ucw_pkg::*;
    localparam int KS = 20;
    logic        ref_clk;
    logic        rst_n;
    logic [3:0]  regAddr;
    logic [15:0] regWdata;
    logic        regWrite;
    logic        regRead;
    logic [15:0] regRdata;
    logic        busSuspendState;
    logic        wide16;
    logic [10:0] frameNumber;
    logic        busKState;
    logic        fifoStrobe;
    logic [7:0]  fifoByte;
    logic [7:0]  lastFifo;
    logic        clockStable;
    logic        clocksRouted;
    logic        driveKState;
    logic        softPullupEnable;
    logic        externalPullupSelect;
    logic        poweredOffSelect;
    logic [3:0]  epCmdIndex;
    logic [7:0]  epCmdCode;
    logic        epCmdPulse;
    logic [15:0] lastRd;
    logic [15:0] lastWr;
    logic        lastSel;
    logic [7:0]  lastEp;
    logic        clkBad;
    logic [7:0]  c;
    logic [15:0] v;
    logic [15:0] scr;
    int          kCnt;
    int          k0;
    int          cyc;
    int          err_total;
    int          n_checks;
    int          seed;

    ucw_if u ();
    ucw_device #(.RESUME_CYCLES(50), .KSTATE_CYCLES(KS), .STABLE_CYCLES(8)) ucw_device_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .bus(u.dev), .busKState(busKState),
        .busSuspendState(busSuspendState), .vbusPresent(1'b1), .wide16(wide16),
        .frameNumber(frameNumber), .clockStable(clockStable), .clocksRouted(clocksRouted),
        .driveKState(driveKState), .softPullupEnable(softPullupEnable),
        .externalPullupSelect(externalPullupSelect), .poweredOffSelect(poweredOffSelect),
        .fifoStrobe(fifoStrobe), .fifoByte(fifoByte),
        .epCmdIndex(epCmdIndex), .epCmdCode(epCmdCode),
        .epCmdPulse(epCmdPulse));
    ucw_host ucw_host_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .bus(u.host), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    ucw_checker ucw_checker_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .hostData(u.hostData), .devData(u.devData),
        .devDataOe(u.devDataOe), .cmdDataSelect(u.cmdDataSelect), .csN(u.csN),
        .wrN(u.wrN), .rdN(u.rdN), .remoteWakeInput(u.remoteWakeInput),
        .suspendOut(u.suspendOut), .intOut(u.intOut));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // bus watcher: what really crossed the wire, not what the host reports
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (!u.rdN && u.devDataOe) lastRd <= u.devData;
        if (!u.wrN) begin
            lastWr  <= u.hostData;
            lastSel <= u.cmdDataSelect;
        end
        if (epCmdPulse) lastEp <= epCmdCode;
        if (fifoStrobe) lastFifo <= fifoByte;
        if (driveKState) kCnt <= kCnt + 1;
        if (clocksRouted && !clockStable) clkBad <= 1'b1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hr(input logic [3:0] ad, output logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= ad;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        d = regRdata;
    endtask

    // busy poll; bounded so a stuck host shows up as a mismatch
    task automatic idle();
        logic [15:0] st;
        st = 16'h0001;
        for (int i = 0; i < 100 && st[0] !== 1'b0; i++) hr(HR_STAT, st);
        chk({15'h0000, st[0]}, 16'h0000);
    endtask

    task automatic hw(input logic [3:0] ad, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr  <= ad;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        idle();
    endtask

    task automatic cmd(input logic [7:0] cc, input logic [7:0] up = 8'h00);
        hw(HR_CMD, {up, cc});
        chk({7'h00, lastSel, lastWr[7:0]}, {8'h01, cc});
    endtask

    task automatic wd(input logic [15:0] d);
        hw(HR_DATA, d);
        chk({7'h00, lastSel, lastWr[7:0]}, {8'h00, d[7:0]});
    endtask

    task automatic rd(output logic [15:0] d);
        logic [15:0] x;
        hr(HR_RDATA, x);
        idle();
        d = lastRd;
    endtask

    task automatic w2(input logic [15:0] d);
        if (wide16) wd(d);
        else begin
            wd({8'h00, d[7:0]});
            wd({8'h00, d[15:8]});
        end
    endtask

    task automatic r2(output logic [15:0] d);
        logic [15:0] lo;
        rd(lo);
        if (wide16) d = lo;
        else begin
            rd(d);
            d = {d[7:0], lo[7:0]};
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        seed = 32'h785a;
        rst_n = 1'b0;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        busSuspendState = 1'b0;
        busKState = 1'b0;
        wide16 = 1'b0;
        frameNumber = 11'h000;
        {cyc, kCnt, err_total, n_checks} = '0;
        clkBad = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        for (int m = 1; m >= 0; m--) begin
            wide16 <= m[0];
            scr = 16'($random(seed));
            cmd(CMD_SCR_WR, 8'($random(seed)));
            w2(scr);
            cmd(CMD_SCR_RD);
            r2(v);
            chk(v, scr);
        end
        frameNumber <= 11'($random(seed));
        cmd(CMD_FRAME_RD);
        r2(v);
        chk(v, {5'h00, frameNumber});
        $display("test scratch and frame done");
        for (int i = 0; i < 3; i++) begin
            c = (i == 2) ? CMD_ACK_SETUP : ((i == 0) ? CMD_STALL : CMD_UNSTALL);
            if (i < 2) c = c | {4'h0, 4'($random(seed))};
            cmd(c);
            chk({4'h0, epCmdIndex, lastEp}, {4'h0, c[3:0], c});
        end
        c = CMD_FIFO_WR | {4'h0, 4'($random(seed)) | 4'h1};
        v = 16'($random(seed));
        cmd(c);
        wd(v);
        chk({8'h00, lastFifo}, {8'h00, v[7:0]});
        $display("test endpoint commands done");
        // no cs wake: the host's own cycles would end suspend early
        cmd(CMD_HWC_WR);
        w2(16'h0005);
        chk({13'h0000, externalPullupSelect, 1'b0, poweredOffSelect}, 16'h0005);
        cmd(CMD_IEN_WR);
        w2(16'h0003);
        w2(16'h0000);
        busSuspendState <= 1'b1;
        cmd(CMD_INT_RD);
        r2(v);
        chk(v & 16'h0100, 16'h0100);
        cmd(CMD_MODE_WR);
        wd(16'h0029);
        chk({14'h0000, u.suspendOut, softPullupEnable}, 16'h0001);
        cmd(CMD_MODE_WR);
        wd(16'h0009);
        for (int i = 0; i < 1000 && u.suspendOut !== 1'b1; i++) @(negedge ref_clk);
        chk({15'h0000, u.suspendOut}, 16'h0001);
        repeat (20) @(posedge ref_clk);
        k0 = kCnt;
        hw(HR_PINS, 16'h0001);
        for (int i = 0; i < 1000 && u.suspendOut !== 1'b0; i++) @(negedge ref_clk);
        for (int i = 0; i < 1000 && clocksRouted !== 1'b1; i++) @(negedge ref_clk);
        chk({14'h0000, clocksRouted, u.suspendOut}, 16'h0002);
        repeat (KS + 20) @(posedge ref_clk);
        chk(16'(kCnt - k0), 16'(KS));
        chk({15'h0000, u.intOut}, 16'h0001);
        hw(HR_PINS, 16'h0000);
        cmd(CMD_INT_RD);
        r2(v);
        chk(v & 16'h0003, 16'h0003);
        chk({15'h0000, u.intOut}, 16'h0000);
        $display("test suspend and wake done");
        // pass 0 locked, pass 1 wrong key, pass 2 right key
        for (int k = 0; k < 3; k++) begin
            if (k > 0) begin
                cmd(CMD_UNLOCK);
                w2((k == 2) ? UNLOCK_KEY : (UNLOCK_KEY ^ 16'h0100));
            end
            cmd(CMD_SCR_WR);
            w2(~scr);
            cmd(CMD_SCR_RD);
            r2(v);
            chk(v, (k == 2) ? ~scr : scr);
        end
        chk({15'h0000, clkBad}, 16'h0000);
        $display("test lock done");
        // a resume started by the bus must not make the device drive its own K-state
        cmd(CMD_MODE_WR);
        wd(16'h0029);
        cmd(CMD_MODE_WR);
        wd(16'h0009);
        chk({15'h0000, u.suspendOut}, 16'h0001);
        k0 = kCnt;
        @(posedge ref_clk);
        busKState <= 1'b1;
        for (int i = 0; i < 1000 && u.suspendOut !== 1'b0; i++) @(negedge ref_clk);
        @(posedge ref_clk);
        busKState <= 1'b0;
        repeat (KS + 20) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({14'h0000, clocksRouted, u.suspendOut}, 16'h0002);
        chk(16'(kCnt - k0), 16'h0000);
        $display("test host resume done");
        stop_test();
    end
endmodule
